//--- verilog/ltmc_host.v
// host controller driving a lin transceiver through its pins
// Function
// - toggle: en low then high within 45 us, txd high at both edges
// - hold txd low at least 12.5 us between en edges
// - wait 12.5 us after en falls before dropping txd
// - keep txd high 12.5 us before raising en
//
// The Avalon-MM slave port and the register addresses are this design's own decisions.
`include "ltmc_map.vh"
module ltmc_host (
    input  wire        clock,
    input  wire        rst_n,
    input  wire [1:0]  avs_address,
    input  wire        avs_read,
    input  wire        avs_write,
    input  wire [31:0] avs_writedata,
    output reg  [31:0] avs_readdata,
    output wire        avs_waitrequest,
    output reg         txdOut,
    output reg         enOut,
    input  wire        rxdIn,
    input  wire        rxdOe,
    input  wire        inhIn
);
    localparam [6:0] ST_IDLE  = 7'h01;
    localparam [6:0] ST_T_ENL = 7'h02;
    localparam [6:0] ST_T_TXL = 7'h04;
    localparam [6:0] ST_T_TXH = 7'h08;
    localparam [6:0] ST_T_FLG = 7'h10;
    localparam [6:0] ST_SLEEP = 7'h20;
    localparam [6:0] ST_WAKE  = 7'h40;
    // counts in clock cycles, cut to the 12-bit counter width on purpose
    localparam integer STEP_I  = `LTMC_STEP_CYC;
    localparam integer WIN_I   = `LTMC_WIN_CYC;
    localparam integer FMIN_I  = `LTMC_FMIN_CYC;
    localparam integer FMAX_I  = `LTMC_FMAX_CYC;
    localparam integer SLEEP_I = `LTMC_SLEEP_CYC;
    localparam integer EWAKE_I = `LTMC_EWAKE_CYC;
    localparam [11:0] STEP_C  = STEP_I[11:0];
    localparam [11:0] WIN_C   = WIN_I[11:0];
    localparam [11:0] FMIN_C  = FMIN_I[11:0];
    localparam [11:0] FMAX_C  = FMAX_I[11:0];
    localparam [11:0] SLEEP_C = SLEEP_I[11:0];
    localparam [11:0] EWAKE_C = EWAKE_I[11:0];

    reg  [6:0]  stateQ;
    reg  [11:0] cntQ;
    reg  [11:0] winQ;
    reg  [11:0] lowQ;
    reg         fastQ;
    reg         flagSeenQ;
    reg         togErrQ;
    reg         txdRegQ;
    reg         ackQ;
    wire        rxSync;
    wire        rxzSync;
    wire        inhSync;

    function [11:0] incSat;
        input [11:0] v;
        begin
            incSat = (v == 12'hFFF) ? v : v + 12'h001;
        end
    endfunction

    // ************************************************************
    // pin synchronisers
    // ************************************************************
    ltmc_sync3 u_rx (
        .clock    (clock),
        .rst_n    (rst_n),
        .pinIn    (rxdIn),
        .resetVal (1'b1),
        .pinOut   (rxSync)
    );
    ltmc_sync3 u_rxz (
        .clock    (clock),
        .rst_n    (rst_n),
        .pinIn    (rxdOe),
        .resetVal (1'b1),
        .pinOut   (rxzSync)
    );
    ltmc_sync3 u_inh (
        .clock    (clock),
        .rst_n    (rst_n),
        .pinIn    (inhIn),
        .resetVal (1'b0),
        .pinOut   (inhSync)
    );

    // ************************************************************
    // avalon slave: one wait cycle on every access
    // ************************************************************
    assign avs_waitrequest = (avs_read | avs_write) & ~ackQ;

    always @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            ackQ         <= 1'b0;
            avs_readdata <= 32'h0000_0000;
        end else begin
            ackQ <= (avs_read | avs_write) & ~ackQ;
            if (avs_read & ~ackQ) begin
                case (avs_address)
                    `LTMC_REG_STAT:
                        avs_readdata <= {24'h00_0000, ~rxzSync, togErrQ, flagSeenQ,
                                         inhSync, enOut, rxSync, fastQ,
                                         stateQ != ST_IDLE};
                    `LTMC_REG_TXD:
                        avs_readdata <= {31'h0000_0000, txdRegQ};
                    default:
                        avs_readdata <= 32'h0000_0000;
                endcase
            end
        end
    end

    wire wrCtrl = avs_write & ackQ & (avs_address == `LTMC_REG_CTRL);
    wire wrTxd  = avs_write & ackQ & (avs_address == `LTMC_REG_TXD);

    // ************************************************************
    // mode sequencer
    // ************************************************************
    // txd defaults high so bus stays recessive outside frames
    always @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            stateQ    <= ST_IDLE;
            cntQ      <= 12'h000;
            winQ      <= 12'h000;
            lowQ      <= 12'h000;
            fastQ     <= 1'b0;
            flagSeenQ <= 1'b0;
            togErrQ   <= 1'b0;
            txdRegQ   <= 1'b1;
            txdOut    <= 1'b1;
            enOut     <= 1'b1;
        end else begin
            if (wrTxd)
                txdRegQ <= avs_writedata[0];
            cntQ <= incSat(cntQ);
            case (stateQ)
                ST_IDLE: begin
                    txdOut <= txdRegQ;
                    if (wrCtrl && avs_writedata[`LTMC_CTRL_TOGGLE] && enOut) begin
                        txdOut    <= 1'b1;
                        enOut     <= 1'b0;
                        cntQ      <= 12'h000;
                        winQ      <= 12'h000;
                        flagSeenQ <= 1'b0;
                        togErrQ   <= 1'b0;
                        stateQ    <= ST_T_ENL;
                    end else if (wrCtrl && avs_writedata[`LTMC_CTRL_SLEEP] && enOut) begin
                        txdOut <= 1'b1;
                        enOut  <= 1'b0;
                        cntQ   <= 12'h000;
                        stateQ <= ST_SLEEP;
                    end else if (wrCtrl && avs_writedata[`LTMC_CTRL_WAKE] && !enOut) begin
                        enOut  <= 1'b1;
                        cntQ   <= 12'h000;
                        stateQ <= ST_WAKE;
                    end
                end
                ST_T_ENL: begin
                    winQ <= incSat(winQ);
                    if (cntQ >= STEP_C - 12'h001) begin
                        txdOut <= 1'b0;
                        cntQ   <= 12'h000;
                        stateQ <= ST_T_TXL;
                    end
                end
                ST_T_TXL: begin
                    winQ <= incSat(winQ);
                    if (cntQ >= STEP_C - 12'h001) begin
                        txdOut <= 1'b1;
                        cntQ   <= 12'h000;
                        stateQ <= ST_T_TXH;
                    end
                end
                ST_T_TXH: begin
                    winQ <= incSat(winQ);
                    if (cntQ >= STEP_C - 12'h001) begin
                        enOut  <= 1'b1;
                        cntQ   <= 12'h000;
                        lowQ   <= 12'h000;
                        // 3 x 250 cycles sits well inside the 900-cycle window
                        togErrQ <= (winQ >= WIN_C);
                        stateQ <= ST_T_FLG;
                    end
                end
                ST_T_FLG: begin
                    // watch for the entry flag, allowing for sync latency
                    if (!rxSync)
                        lowQ <= incSat(lowQ);
                    if (cntQ >= FMAX_C + 12'h008) begin
                        if (lowQ >= FMIN_C - 12'h002) begin
                            flagSeenQ <= 1'b1;
                            fastQ     <= 1'b1;
                        end else begin
                            fastQ <= 1'b0;
                        end
                        stateQ <= ST_IDLE;
                    end
                end
                ST_SLEEP: begin
                    // release en and keep txd high; device sleeps after entry delay
                    if (cntQ >= SLEEP_C)
                        fastQ <= 1'b0;
                    if (wrCtrl && avs_writedata[`LTMC_CTRL_WAKE]) begin
                        enOut  <= 1'b1;
                        cntQ   <= 12'h000;
                        stateQ <= ST_WAKE;
                    end
                end
                ST_WAKE: begin
                    // give the device time to raise inhibit before traffic
                    if (cntQ >= EWAKE_C)
                        stateQ <= ST_IDLE;
                end
                default: begin
                    stateQ <= ST_IDLE;
                end
            endcase
        end
    end
endmodule

//--- verilog/ltmc_map.vh
// constants for the lin transceiver mode controller (host side)
`ifndef LTMC_MAP_VH
`define LTMC_MAP_VH
// ************************************************************
// timing, clock 20 MHz
// ************************************************************
`define LTMC_CLK_MHZ          20
// times in nanoseconds, as printed in microseconds times 1000
`define LTMC_TOGGLE_WIN_NS    45000
`define LTMC_TOGGLE_STEP_NS   12500
`define LTMC_FLAG_MIN_NS      1875
`define LTMC_FLAG_MAX_NS      6250
`define LTMC_SLEEP_MAX_NS     91000
`define LTMC_EN_WAKE_NS       15000
`define LTMC_CLK_NS           50
// step, flag max, sleep and wake times round up; toggle window and flag min round down
`define LTMC_STEP_CYC   ((`LTMC_TOGGLE_STEP_NS + `LTMC_CLK_NS - 1) / `LTMC_CLK_NS)
`define LTMC_WIN_CYC    (`LTMC_TOGGLE_WIN_NS / `LTMC_CLK_NS)
`define LTMC_FMIN_CYC   (`LTMC_FLAG_MIN_NS / `LTMC_CLK_NS)
`define LTMC_FMAX_CYC   ((`LTMC_FLAG_MAX_NS + `LTMC_CLK_NS - 1) / `LTMC_CLK_NS)
`define LTMC_SLEEP_CYC  ((`LTMC_SLEEP_MAX_NS + `LTMC_CLK_NS - 1) / `LTMC_CLK_NS)
`define LTMC_EWAKE_CYC  ((`LTMC_EN_WAKE_NS + `LTMC_CLK_NS - 1) / `LTMC_CLK_NS)
// ************************************************************
// registers (word addresses on avalon)
// ************************************************************
`define LTMC_REG_CTRL    2'h0
`define LTMC_REG_STAT    2'h1
`define LTMC_REG_TXD     2'h2
// ctrl fields: write 1 to start a command
`define LTMC_CTRL_SLEEP  0
`define LTMC_CTRL_WAKE   1
`define LTMC_CTRL_TOGGLE 2
// status fields
`define LTMC_ST_BUSY     0
`define LTMC_ST_FAST     1
`define LTMC_ST_RX       2
`define LTMC_ST_EN       3
`define LTMC_ST_INH      4
`define LTMC_ST_FLAGSEEN 5
`define LTMC_ST_TOGERR   6
`define LTMC_ST_RXZ      7
`endif

//--- verilog/ltmc_sync3.v
// three-flop pin synchroniser with agree-filter
module ltmc_sync3 (
    input  wire clock,
    input  wire rst_n,
    input  wire pinIn,
    input  wire resetVal,
    output reg  pinOut
);
    reg s1Q;
    reg s2Q;
    reg s3Q;
    reg initQ;
    // ************************************************************
    // sync chain
    // ************************************************************
    // async reset loads a constant; strap level taken after release
    always @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            s1Q    <= 1'b1;
            s2Q    <= 1'b1;
            s3Q    <= 1'b1;
            pinOut <= 1'b1;
            initQ  <= 1'b0;
        end else begin
            s1Q   <= pinIn;
            s2Q   <= s1Q;
            s3Q   <= s2Q;
            initQ <= 1'b1;
            if (!initQ)
                pinOut <= resetVal;
            else if (s2Q == s3Q)
                pinOut <= s3Q;
        end
    end
endmodule

//--- dv/ltmc_dev_model.sv
// behavioural lin transceiver seen at its pins
`include "ltmc_map.vh"
module ltmc_dev_model (
    input  logic clock,
    input  logic txd,
    input  logic en,
    input  logic wakePin,
    output logic rxd,
    output logic rxdOe,
    output logic regulator_inhibit_out
);
    timeunit 1ns;
    timeprecision 1ns;
    // ****
    // pins
    // ****
    localparam int STEP = `LTMC_STEP_CYC, WIN = `LTMC_WIN_CYC, HOLD = 10, FLAG = 80;
    localparam int SLEEP = 1400, WWAKE = 960, BWAKE = 1400;
    int   eLo = 0, tLo = 0, tHi = 0, hold = 0, flag = 0, wCnt = 0, bCnt = 0;
    logic asleep = 0, awake = 0, fast = 0, dip = 0, wRef = 0, bus;
    logic wS1 = 0, wS2 = 0, wMove = 0;
    // fault and remote-node levels, set by the bench
    logic supplyLow = 0, overTemp = 0, remoteDom = 0;
    // only a firm low drives, so a floating txd stays recessive
    assign bus = !remoteDom && !(en && !asleep && txd === 1'b0
        && hold >= HOLD && tLo < 100000
        && !supplyLow && !overTemp);
    assign rxd = (flag > 0 || awake) ? 1'b0 : (overTemp || bus);
    assign rxdOe = !asleep;
    assign regulator_inhibit_out = !asleep && !overTemp;
    always @(posedge clock) begin
        eLo <= en ? 0 : eLo + 1;
        tLo <= txd === 1'b0 ? tLo + 1 : 0;
        tHi <= txd === 1'b0 ? 0 : tHi + 1;
        hold <= en ? hold + (hold < HOLD) : 0;
        flag <= flag > 0 ? flag - 1 : 0;
        wS1 <= wakePin;
        wS2 <= wS1;
        wMove <= !en && !asleep && (wMove || wS1 != wS2);
        wCnt <= asleep && wS2 != wRef ? wCnt + 1 : 0;
        bCnt <= asleep && !bus ? bCnt + 1 : 0;
        dip <= !en && (dip || txd && tLo >= STEP && eLo - tLo >= STEP);
        if (en && eLo > 0 && eLo <= WIN && dip && txd && tHi >= STEP) begin
            fast <= !fast;
            flag <= fast ? 0 : FLAG;
        end
        if (en) begin
            asleep <= 1'b0;
            awake <= 1'b0;
        end else if (eLo == SLEEP && !wMove) begin
            asleep <= 1'b1;
            wRef <= wS2;
        end else if (eLo == SLEEP) begin
            awake <= 1'b1;
        end else if (wCnt == WWAKE || asleep && bus && bCnt >= BWAKE) begin
            asleep <= 1'b0;
            awake <= 1'b1;
        end
    end
endmodule

//--- dv/ltmc_host_assertions.sv
// checker for the lin mode controller's bus and pin timing
`include "ltmc_map.vh"
module ltmc_host_assertions (
    input wire        clock,
    input wire        rst_n,
    input wire [1:0]  avs_address,
    input wire        avs_read,
    input wire        avs_write,
    input wire [31:0] avs_readdata,
    input wire        avs_waitrequest,
    input wire        txdOut,
    input wire        enOut
);
    timeunit 1ns;
    timeprecision 1ns;
    // ****
    // checks
    // ****
    localparam int STEP = `LTMC_STEP_CYC, WIN = `LTMC_WIN_CYC;
    logic [11:0] enLo_q, txLo_q, txHi_q;
    logic        dip_q;
    wire         req = avs_read | avs_write;
    // a long sleep may wrap enLo_q; harmless, no dip is seen then
    always @(posedge clock or negedge rst_n)
        enLo_q <= !rst_n || enOut ? 12'h0 : enLo_q + 12'h1;
    always @(posedge clock or negedge rst_n)
        txLo_q <= !rst_n || txdOut ? 12'h0 : txLo_q + 12'h1;
    always @(posedge clock or negedge rst_n)
        txHi_q <= !rst_n || !txdOut ? 12'h0 : txHi_q + {11'h0, ~&txHi_q};
    always @(posedge clock or negedge rst_n)
        dip_q <= !rst_n || enOut ? 1'b0 : dip_q | !txdOut;
    default clocking cb @(posedge clock); endclocking
    default disable iff (!rst_n);
    sequence s_enFall; $fell(enOut); endsequence
    sequence s_txdHeld; txdOut [*8]; endsequence
    a_wait_first: assert property ($rose(req) |-> avs_waitrequest)
        else $error("no wait cycle");
    a_wait_one: assert property (req && avs_waitrequest |=> !avs_waitrequest)
        else $error("wait too long");
    a_unmapped_zero: assert property (avs_read && !avs_waitrequest && avs_address == 2'h3
        |-> avs_readdata == 32'h0000_0000) else $error("unmapped read nonzero");
    a_txd_high_fall: assert property (s_enFall |-> s_txdHeld)
        else $error("txd low at enable fall");
    a_txd_fall_gap: assert property ($fell(txdOut) && !enOut |-> enLo_q >= STEP)
        else $error("txd fell too soon");
    a_txd_low_hold: assert property ($rose(txdOut) && !enOut |-> txLo_q >= STEP)
        else $error("txd low too short");
    a_en_rise_txd: assert property ($rose(enOut) |-> txdOut && txHi_q >= STEP)
        else $error("txd not settled high");
    a_toggle_window: assert property ($rose(enOut) && dip_q |-> enLo_q <= WIN)
        else $error("toggle too long");
endmodule
bind ltmc_host ltmc_host_assertions chk_u (.clock, .rst_n, .avs_address, .avs_read,
    .avs_write, .avs_readdata, .avs_waitrequest, .txdOut, .enOut);

//--- dv/testbench.sv
// self-checking bench for the lin mode controller
`include "ltmc_map.vh"
module testbench;
    timeunit 1ns;
    timeprecision 1ns;
    // ****
    // bench
    // ****
    logic        clock = 0, rst_n = 0, avs_read = 0, avs_write = 0, wakePin = 0, b;
    logic [1:0]  avs_address = 2'h0;
    logic [31:0] avs_writedata = 32'h0, rd, expQ[$], maskQ[$];
    wire  [31:0] avs_readdata;
    wire         avs_waitrequest, txdOut, enOut, rxdDrv, rxdOe, inhIn;
    wire         rxdIn = rxdOe ? rxdDrv : 1'b1;  // pull-up on the floated pin
    int          n_mismatch = 0, num_checks = 0, i;
    ltmc_host dut_u (.clock, .rst_n, .avs_address, .avs_read, .avs_write, .avs_writedata,
        .avs_readdata, .avs_waitrequest, .txdOut, .enOut, .rxdIn, .rxdOe, .inhIn);
    ltmc_dev_model dev_u (.clock, .txd(txdOut), .en(enOut), .wakePin, .rxd(rxdDrv),
        .rxdOe, .regulator_inhibit_out(inhIn));
    initial forever #25 clock = ~clock;
    task automatic chk(input logic [31:0] seen, exp);
        num_checks++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("ERROR %0t: got %h want %h", $time, seen, exp);
        end
    endtask
    task automatic op(input logic w, input logic [1:0] a, input logic [31:0] d);
        @(posedge clock);
        avs_address <= a;
        avs_writedata <= d;
        avs_write <= w;
        avs_read <= !w;
        do @(posedge clock); while (avs_waitrequest !== 1'b0);
        rd = avs_readdata;
        avs_write <= 1'b0;
        avs_read <= 1'b0;
    endtask
    task automatic rx(input logic [1:0] a, input logic [31:0] m, e);
        maskQ.push_back(m);
        expQ.push_back(e);
        op(1'b0, a, 32'h0);
    endtask
    task automatic idle;
        do rx(`LTMC_REG_STAT, 32'h0, 32'h0); while (rd[0] !== 1'b0);
    endtask
    task automatic wrap_up;
        $display("checks %0d mismatches %0d", num_checks, n_mismatch);
        if (n_mismatch == 0 && num_checks > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask
    always @(posedge clock)
        if (avs_read && avs_waitrequest === 1'b0)
            chk(avs_readdata & maskQ.pop_front(), expQ.pop_front());
    initial begin
        #2000000;
        n_mismatch++;
        wrap_up;
    end
    initial begin
        repeat (4) @(posedge clock);
        rst_n <= 1'b1;
        void'($urandom(14458));
        repeat (8) @(posedge clock);
        rx(`LTMC_REG_STAT, 32'hFF, 32'h1C);
        op(1'b1, 2'h3, $urandom);
        rx(2'h3, 32'hFFFF_FFFF, 32'h0);
        $display("test reset done");
        for (i = 0; i < 6; i++) begin
            b = 1'($urandom);
            op(1'b1, `LTMC_REG_TXD, {31'h0, b});
            repeat (6) @(posedge clock);
            chk({31'h0, dev_u.bus}, {31'h0, b});
            rx(`LTMC_REG_STAT, 32'hDF, {29'h3, b, 2'h0});
        end
        $display("test txd done");
        op(1'b1, `LTMC_REG_TXD, 32'h0);
        dev_u.supplyLow <= 1'b1;
        repeat (6) @(posedge clock);
        rx(`LTMC_REG_STAT, 32'hDF, 32'h1C);
        dev_u.supplyLow <= 1'b0;
        dev_u.overTemp <= 1'b1;
        repeat (6) @(posedge clock);
        rx(`LTMC_REG_STAT, 32'hDF, 32'h0C);
        dev_u.overTemp <= 1'b0;
        repeat (6) @(posedge clock);
        rx(`LTMC_REG_STAT, 32'hDF, 32'h18);
        op(1'b1, `LTMC_REG_TXD, 32'h1);
        $display("test fault done");
        for (i = 0; i < 3; i++) begin
            op(1'b1, `LTMC_REG_CTRL, 32'h4);
            idle;
            rx(`LTMC_REG_STAT, 32'hFF, i == 1 ? 32'h1C : 32'h3E);
        end
        $display("test toggle done");
        op(1'b1, `LTMC_REG_CTRL, 32'h1);
        repeat (2000) @(posedge clock);
        rx(`LTMC_REG_STAT, 32'hDE, 32'h84);
        wakePin <= 1'b1;
        repeat (100) @(posedge clock);
        wakePin <= 1'b0;
        repeat (100) @(posedge clock);
        rx(`LTMC_REG_STAT, 32'hDE, 32'h84);
        wakePin <= 1'b1;
        repeat (1200) @(posedge clock);
        rx(`LTMC_REG_STAT, 32'hDE, 32'h10);
        op(1'b1, `LTMC_REG_CTRL, 32'h2);
        idle;
        rx(`LTMC_REG_STAT, 32'hDF, 32'h1C);
        op(1'b1, `LTMC_REG_CTRL, 32'h1);
        repeat (2000) @(posedge clock);
        // a short dominant must not wake, a long one must
        for (i = 0; i < 2; i++) begin
            dev_u.remoteDom <= 1'b1;
            repeat (i == 0 ? 400 : 1500) @(posedge clock);
            dev_u.remoteDom <= 1'b0;
            repeat (100) @(posedge clock);
            rx(`LTMC_REG_STAT, 32'hDE, i == 0 ? 32'h84 : 32'h10);
        end
        op(1'b1, `LTMC_REG_CTRL, 32'h2);
        idle;
        op(1'b1, `LTMC_REG_CTRL, 32'h1);
        repeat (200) @(posedge clock);
        wakePin <= 1'b0;
        repeat (2000) @(posedge clock);
        rx(`LTMC_REG_STAT, 32'hDE, 32'h10);
        op(1'b1, `LTMC_REG_CTRL, 32'h2);
        idle;
        rx(`LTMC_REG_STAT, 32'hDF, 32'h1C);
        $display("test sleep done");
        wrap_up;
    end
endmodule
